// ### fpm_pkg.sv
// Package for the flash protection mode control block
// Functional notes
// - Reset and factory default state is unprotected, debug flash access limited only by per-row protection.
// - A user request may move the state from unprotected to debug-locked.
// - Debug-locked state refuses flash accesses arriving through the debug port, except full-array erase.
// - Debug-locked returns to unprotected only after a completed full-array erase.
// - A user request may move the state from unprotected to permanent lock.
// - Permanent lock blocks every debug port access, flash or otherwise.
// - Permanent lock rejects any flash erase requested from outside the chip.
// - Permanent lock is never left by any later request or erase.
// - Per-row protection: write-protected rows reject writes, read-protected rows block reads.
// - Firmware system-call flash reads, writes and erases always proceed.
package fpm_pkg;
	typedef enum logic [1:0] {
		FPM_OPEN = 2'b00,
		FPM_PROTECTED = 2'b01,
		FPM_KILL = 2'b10
	} fpm_mode_type;

	typedef enum logic [1:0] {
		FPM_OP_READ = 2'b00,
		FPM_OP_WRITE = 2'b01,
		FPM_OP_ROW_ERASE = 2'b10,
		FPM_OP_CHIP_ERASE = 2'b11
	} fpm_op_type;

	localparam int FPM_ROW_W = 9;
	localparam int FPM_ROWS = 512;

	typedef struct packed {
		logic valid;
		fpm_op_type op;
		logic [FPM_ROW_W-1:0] row;
	} fpm_req_type;

	typedef struct packed {
		logic grant;
		logic deny;
	} fpm_resp_type;

	localparam logic FPM_ROW_PROT_RESET = 1'b0;
endpackage : fpm_pkg

// ### fpm_access_check.sv
// Per-request access decision for flash and debug traffic
`timescale 1ns/1ps
module fpm_access_check
	import fpm_pkg::*;
#(
	parameter int ROWS = FPM_ROWS
) (
	input wire fpm_mode_type i_mode, // Current protection mode
	input wire logic i_is_debug, // Request came from the debug port
	input wire fpm_req_type i_req, // Flash request
	input wire logic [ROWS-1:0] i_wr_prot, // Row write protection
	input wire logic [ROWS-1:0] i_rd_prot, // Row read protection
	output logic o_allow // Request may proceed
);
	always_comb begin
		o_allow = 1'b1;
		if (i_is_debug) begin
			if (i_mode == FPM_KILL) begin
				o_allow = 1'b0;
			end else if (i_mode == FPM_PROTECTED && i_req.op != FPM_OP_CHIP_ERASE) begin
				o_allow = 1'b0;
			end else if (i_req.op == FPM_OP_READ && i_rd_prot[i_req.row]) begin
				o_allow = 1'b0;
			end else if (i_req.op != FPM_OP_READ && i_req.op != FPM_OP_CHIP_ERASE
				&& i_wr_prot[i_req.row]) begin
				o_allow = 1'b0;
			end
		end
		// Firmware system calls bypass all protection
		if (!i_is_debug) begin
			o_allow = 1'b1;
		end
	end
endmodule : fpm_access_check

// ### fpm_flash_protect.sv
// Flash protection mode control top
`timescale 1ns/1ps
module fpm_flash_protect
	import fpm_pkg::*;
#(
	parameter int ROWS = FPM_ROWS
) (
	input wire logic i_clock, // System clock
	input wire logic i_rst, // Synchronous reset, active high
	input wire logic i_set_protected, // Firmware request: go to protected
	input wire logic i_set_kill, // Firmware request: go to kill
	input wire logic [ROWS-1:0] i_wr_prot, // Row write protection settings
	input wire logic [ROWS-1:0] i_rd_prot, // Row read protection settings
	input wire fpm_req_type i_dbg_req, // Flash request from debug port
	input wire logic i_dbg_other, // Non-flash debug access request
	input wire fpm_req_type i_fw_req, // Flash request from system call
	input wire logic i_chip_erase_done, // Flash array erase completed
	output fpm_mode_type o_mode, // Current protection mode
	output fpm_resp_type o_dbg_resp, // Debug flash request answer
	output fpm_resp_type o_fw_resp, // System call answer
	output logic o_dbg_other_grant, // Non-flash debug access granted
	output logic o_dbg_other_deny, // Non-flash debug access refused
	output logic o_chip_erase_start // Launch full-array erase
);
	// Port index of each requester in the shared access check loop
	localparam int NUM_PORTS = 2;
	localparam int PORT_DBG = 0;
	localparam int PORT_FW = 1;

	// Protection mode state
	fpm_mode_type mode_ff;
	fpm_mode_type nxt_mode;

	// Chip erase launch and the unlock it may earn
	logic erase_start_ff;
	logic nxt_erase_start;
	logic erase_pend_ff;
	logic nxt_erase_pend;

	// Registered answers
	fpm_resp_type dbg_resp_ff;
	fpm_resp_type nxt_dbg_resp;
	fpm_resp_type fw_resp_ff;
	fpm_resp_type nxt_fw_resp;
	logic other_grant_ff;
	logic nxt_other_grant;
	logic other_deny_ff;
	logic nxt_other_deny;

	// Decisions and decoded events
	wire logic [NUM_PORTS-1:0] port_allow;
	logic dbg_allow;
	logic fw_allow;
	logic lock_req;
	logic kill_req;
	logic dbg_chip_erase;
	logic fw_chip_erase;
	logic unlock_ok;

	// Same check module for both requesters; only the debug side is restricted
	generate
		for (genvar gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			fpm_access_check #(
				.ROWS(ROWS)
			) i_fpm_access_check (
				.i_mode(mode_ff),
				.i_is_debug(gi == PORT_DBG),
				.i_req((gi == PORT_DBG) ? i_dbg_req : i_fw_req),
				.i_wr_prot(i_wr_prot),
				.i_rd_prot(i_rd_prot),
				.o_allow(port_allow[gi])
			);
		end
	endgenerate

	assign dbg_allow = port_allow[PORT_DBG];
	assign fw_allow = port_allow[PORT_FW];

	// Mode requests only count in the open state
	always_comb begin
		lock_req = mode_ff == FPM_OPEN && i_set_protected;
		kill_req = mode_ff == FPM_OPEN && i_set_kill;
		dbg_chip_erase = i_dbg_req.valid && i_dbg_req.op == FPM_OP_CHIP_ERASE && dbg_allow;
		fw_chip_erase = i_fw_req.valid && i_fw_req.op == FPM_OP_CHIP_ERASE;
		// Only an erase this block launched unlocks, not a stray done pulse
		unlock_ok = mode_ff == FPM_PROTECTED && erase_pend_ff && i_chip_erase_done;
	end

	// Kill wins over protected when both land together: stronger lock
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			FPM_OPEN: begin
				if (kill_req) begin
					nxt_mode = FPM_KILL;
				end else if (lock_req) begin
					nxt_mode = FPM_PROTECTED;
				end
			end
			FPM_PROTECTED: begin
				// Kill and repeated lock requests leave the mode alone
				nxt_mode = FPM_PROTECTED;
				if (unlock_ok) begin
					nxt_mode = FPM_OPEN;
				end
			end
			FPM_KILL: begin
				// No request or erase ever leaves kill
				nxt_mode = FPM_KILL;
			end
			default: begin
				// Unused code: fall to the strongest lock, never to open
				nxt_mode = FPM_KILL;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			// Not retained across reset; no nonvolatile copy here
			mode_ff <= FPM_OPEN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// Pending flag dies outside protected so no old erase unlocks later
	always_comb begin
		nxt_erase_pend = erase_pend_ff;
		nxt_erase_start = 1'b0;
		if (mode_ff != FPM_PROTECTED || unlock_ok) begin
			nxt_erase_pend = 1'b0;
		end
		if (dbg_chip_erase) begin
			nxt_erase_start = 1'b1;
			if (mode_ff == FPM_PROTECTED) begin
				nxt_erase_pend = 1'b1;
			end
		end
		// Firmware erase runs in any mode but earns no unlock
		if (fw_chip_erase) begin
			nxt_erase_start = 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			erase_pend_ff <= 1'b0;
			erase_start_ff <= 1'b0;
		end else begin
			erase_pend_ff <= nxt_erase_pend;
			erase_start_ff <= nxt_erase_start;
		end
	end

	// Debug flash answer, one cycle after the request
	always_comb begin
		nxt_dbg_resp = '0;
		if (i_dbg_req.valid) begin
			if (dbg_allow) begin
				nxt_dbg_resp.grant = 1'b1;
			end else begin
				nxt_dbg_resp.deny = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			dbg_resp_ff <= '0;
		end else begin
			dbg_resp_ff <= nxt_dbg_resp;
		end
	end

	// Firmware answer; deny is kept for symmetry and never rises
	always_comb begin
		nxt_fw_resp = '0;
		if (i_fw_req.valid) begin
			if (fw_allow) begin
				nxt_fw_resp.grant = 1'b1;
			end else begin
				nxt_fw_resp.deny = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fw_resp_ff <= '0;
		end else begin
			fw_resp_ff <= nxt_fw_resp;
		end
	end

	// Non-flash debug traffic is only stopped by kill
	always_comb begin
		nxt_other_grant = 1'b0;
		nxt_other_deny = 1'b0;
		if (i_dbg_other) begin
			if (mode_ff == FPM_KILL) begin
				nxt_other_deny = 1'b1;
			end else begin
				nxt_other_grant = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			other_grant_ff <= 1'b0;
			other_deny_ff <= 1'b0;
		end else begin
			other_grant_ff <= nxt_other_grant;
			other_deny_ff <= nxt_other_deny;
		end
	end

	// Every output straight from its flop
	assign o_mode = mode_ff;
	assign o_dbg_resp = dbg_resp_ff;
	assign o_fw_resp = fw_resp_ff;
	assign o_dbg_other_grant = other_grant_ff;
	assign o_dbg_other_deny = other_deny_ff;
	assign o_chip_erase_start = erase_start_ff;
endmodule : fpm_flash_protect

// ### fpm_chk.sv
// Assertion checker for the protection mode block, with its bind
`timescale 1ns/1ps
module fpm_chk
	import fpm_pkg::*;
(
	input wire logic i_clock, // Clock
	input wire logic i_rst, // Reset
	input wire logic i_set_protected, // Lock req
	input wire logic i_set_kill, // Kill req
	input wire fpm_req_type i_dbg_req, // Debug req
	input wire logic i_dbg_other, // Debug other
	input wire fpm_req_type i_fw_req, // Fw req
	input wire logic i_chip_erase_done, // Erase done
	input wire fpm_mode_type o_mode, // Mode
	input wire fpm_resp_type o_dbg_resp, // Debug answer
	input wire fpm_resp_type o_fw_resp, // Fw answer
	input wire logic o_dbg_other_deny, // Other refused
	input wire logic o_dbg_other_grant, // Other granted
	input wire logic o_chip_erase_start // Erase launch
);
	logic k, p, o;
	assign k = o_mode == FPM_KILL;
	assign p = o_mode == FPM_PROTECTED;
	assign o = o_mode == FPM_OPEN;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	AST_KEEP: assert property (k |=> k) else $error("kill left");
	AST_OTH: assert property (k && i_dbg_other |=> o_dbg_other_deny) else $error("oth");
	AST_EXT: assert property (k && i_dbg_req.valid |=> o_dbg_resp == 2'b01) else $error("ext");
	AST_PROT: assert property (p && i_dbg_req.valid && i_dbg_req.op != FPM_OP_CHIP_ERASE
		|=> o_dbg_resp.deny) else $error("prot");
	AST_FW: assert property (i_fw_req.valid |=> o_fw_resp == 2'b10) else $error("fw");
	AST_LOCK: assert property (o && i_set_protected && !i_set_kill |=> p) else $error("lock");
	AST_KILL: assert property (o && i_set_kill |=> k) else $error("kill");
	AST_HOLD: assert property (p && !i_chip_erase_done |=> $stable(o_mode)) else $error("hold");
	AST_UNL: assert property (p && i_dbg_req.valid && i_dbg_req.op == FPM_OP_CHIP_ERASE
		|=> o_dbg_resp.grant && o_chip_erase_start) else $error("unl");
	AST_NOEXT: assert property (k && !(i_fw_req.valid && i_fw_req.op == FPM_OP_CHIP_ERASE)
		|=> !o_chip_erase_start) else $error("ext erase");
	AST_OPN: assert property (!k && i_dbg_other |=> o_dbg_other_grant) else $error("opn");
endmodule : fpm_chk

bind fpm_flash_protect fpm_chk i_fpm_chk (.i_clock, .i_rst, .i_set_protected, .i_set_kill,
	.i_dbg_req, .i_dbg_other, .i_fw_req, .i_chip_erase_done, .o_mode, .o_dbg_resp,
	.o_fw_resp, .o_dbg_other_deny, .o_dbg_other_grant, .o_chip_erase_start);

// ### fpm_dbg_model.sv
// Debugger model issuing single-cycle debug requests
`timescale 1ns/1ps
module fpm_dbg_model
	import fpm_pkg::*;
(
	input wire logic i_clock, // Clock
	output fpm_req_type o_req, // Flash req
	output logic o_other // Other req
);
	initial o_req = '0;
	initial o_other = 1'b0;
	task automatic send(input fpm_op_type op, input logic [8:0] r, input logic ot);
		@(posedge i_clock);
		o_req <= '{1'b1, op, r};
		o_other <= ot;
		@(posedge i_clock);
		// Stale row inverted so a missed valid check shows
		o_req <= '{1'b0, op, ~r};
		o_other <= 1'b0;
	endtask : send
endmodule : fpm_dbg_model

// ### fpm_flash_protect_tb_top.sv
// Self-checking bench for the protection mode block
`timescale 1ns/1ps
module fpm_flash_protect_tb_top
	import fpm_pkg::*;
;
	logic i_clock, i_rst, sp, sk, dn, oth, og, od, es;
	logic [FPM_ROWS-1:0] wr, rd;
	fpm_req_type dq, fq;
	fpm_mode_type mo, md;
	fpm_resp_type dr, fr;
	int err_count, comparisons, seed;
	int cyc = 0;
	fpm_flash_protect i_fpm_flash_protect (.i_clock, .i_rst, .i_set_protected(sp),
		.i_set_kill(sk), .i_wr_prot(wr), .i_rd_prot(rd), .i_dbg_req(dq), .i_dbg_other(oth),
		.i_fw_req(fq), .i_chip_erase_done(dn), .o_mode(mo), .o_dbg_resp(dr),
		.o_fw_resp(fr), .o_dbg_other_grant(og), .o_dbg_other_deny(od), .o_chip_erase_start(es));
	fpm_dbg_model i_fpm_dbg_model (.i_clock, .o_req(dq), .o_other(oth));
	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input logic [6:0] s, input logic [6:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	function automatic logic [6:0] ex(input fpm_op_type op, input logic [8:0] r, input logic ot);
		logic d;
		d = md == FPM_KILL || (md == FPM_PROTECTED && op != FPM_OP_CHIP_ERASE) ||
			(md == FPM_OPEN && (op == FPM_OP_READ ? rd[r] : op != FPM_OP_CHIP_ERASE && wr[r]));
		// Launch: granted debug chip erase, or firmware chip erase (paired with row erase)
		return {~d, d, ot && md != FPM_KILL, ot && md == FPM_KILL, 2'b10,
			(op == FPM_OP_CHIP_ERASE && !d) || op == FPM_OP_ROW_ERASE};
	endfunction : ex
	task automatic step(input fpm_op_type op, input logic [8:0] r, input logic ot);
		fork
			i_fpm_dbg_model.send(op, r, ot);
			begin
				@(posedge i_clock);
				// Neighbouring op so a debug erase in kill is not hidden
				fq <= '{1'b1, fpm_op_type'(op ^ 2'b01), ~r};
				@(posedge i_clock);
				fq <= '0;
			end
		join
		#1;
		chk({dr, og, od, fr, es}, ex(op, r, ot));
	endtask : step
	task automatic ev(input logic p, input logic k, input logic e, input fpm_mode_type m);
		@(posedge i_clock);
		{sp, sk, dn} <= {p, k, e};
		@(posedge i_clock);
		{sp, sk, dn} <= 3'h0;
		#1;
		md = m;
		chk({5'h0, mo}, {5'h0, m});
	endtask : ev
	initial begin
		seed = 32'h44530D27;
		{i_rst, sp, sk, dn} = 4'h8;
		fq = '0;
		md = FPM_OPEN;
		// Pattern repeats every 32 rows; random rows still hit both settings
		wr = {16{$random(seed)}};
		rd = {16{$random(seed)}};
		repeat (12) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		#1;
		chk({5'h0, mo}, 7'h0);
		repeat (24) step(fpm_op_type'(2'($random(seed))), 9'($random(seed)), 1'($random(seed)));
		$display("test open end");
		ev(1, 0, 0, FPM_PROTECTED);
		ev(0, 1, 0, FPM_PROTECTED);
		ev(0, 0, 1, FPM_PROTECTED);
		for (int i = 0; i < 4; i++) step(fpm_op_type'(i), 9'($random(seed)), 1'b0);
		ev(0, 0, 1, FPM_OPEN);
		$display("test unlock end");
		ev(1, 1, 0, FPM_KILL);
		for (int i = 0; i < 4; i++) step(fpm_op_type'(i), 9'($random(seed)), 1'b1);
		ev(1, 0, 1, FPM_KILL);
		$display("test kill end");
		// Reset in mid-run: mode is not kept across reset
		@(posedge i_clock);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		#1;
		md = FPM_OPEN;
		chk({5'h0, mo}, 7'h0);
		step(FPM_OP_READ, 9'($random(seed)), 1'b1);
		$display("test reset end");
		test_done();
	end
endmodule : fpm_flash_protect_tb_top
